// file: pbmc_host.sv
// Contract
// - host inserts the 64-bit key to lift protection, removes it to restore.
// - device holds busy low during download; host waits until busy negates.
// - host writes control then confirmation register to reach Normal first.
// - sequence enters deep_sleep_mode; wakeup_register access plus 3us returns Normal.
// - write is chip select with write strobe, read with output enable, glitch-free.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module pbmc_host
	import pbmc_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	output logic      [12:0] DEV_ADDR_O,
	input  wire logic [15:0] DEV_D_I,
	output logic      [15:0] DEV_D_O,
	output logic             DEV_D_OE_O,
	output logic             DEV_CE_N_O,
	output logic             DEV_OE_N_O,
	output logic             DEV_WE_N_O,
	output logic             DEV_RESET_INPUT_N_N_O,
	output logic             DEV_LOCK_N_O,
	input  wire logic        DEV_BUSY_N_I,
	input  wire logic        DEV_IRQ_N_I
);
	////////////////////////////////////////////////////////////////////////////
	// per-step device access: {write, last, addr, data}
	function automatic logic [30:0] step_fn(
		input logic [3:0]  cmd,
		input logic [4:0]  step,
		input logic [12:0] a,
		input logic [15:0] d
	);
		logic [30:0] r;
		r = {1'b0, 1'b1, a, 16'h0000};
		case (cmd)
			CMD_READ:   r = {1'b0, 1'b1, a, 16'h0000};
			CMD_WRITE:  r = {1'b1, 1'b1, a, d}; // key words go out as plain writes
			CMD_NORMAL: r = (step == 5'h00) ? {1'b1, 1'b0, DEV_CTRL_ADDR, MODE_NORMAL}
			                                 : {1'b1, 1'b1, DEV_CONF_ADDR, ~MODE_NORMAL};
			CMD_RSTMOD: r = (step == 5'h00) ? {1'b1, 1'b0, DEV_CTRL_ADDR, MODE_RESET}
			                                 : {1'b1, 1'b1, DEV_CONF_ADDR, ~MODE_RESET};
			CMD_SLEEP:  r = (step == 5'h00) ? {1'b1, 1'b0, DEV_CTRL_ADDR, MODE_DEEP}
			                                 : {1'b1, 1'b1, DEV_CONF_ADDR, ~MODE_DEEP};
			CMD_WAKE:   r = {1'b0, 1'b1, DEV_NOP_ADDR, 16'h0000};
			CMD_UID:    r = {1'b0, (step == 5'(UID_BYTES - 1)), DEV_UID_BASE + 13'(step), 16'h0000};
			CMD_STICKY_LOCK_BIT:  r = {1'b1, 1'b1, DEV_OUTCTL_ADDR, STICKY_LOCK_BIT_MASK};
			default:    r = {1'b0, 1'b1, a, 16'h0000};
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	pbmc_state_e state_q;
	pbmc_state_e state_d;
	logic [9:0]  cnt_q;
	logic [9:0]  cnt_d;
	logic [4:0]  step_q;
	logic [3:0]  cmd_q;
	logic [12:0] addr_q;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	logic        rej_q;
	logic        lock_q;
	logic [3:0]  uid_idx_q;
	logic [7:0]  uid_byte;
	logic [30:0] cur;

	// bus decode
	wire        apb_acc   = PSEL_I & PENABLE_I;
	wire        apb_wr    = apb_acc & PWRITE_I;
	wire        known     = (PADDR_I[1:0] == 2'b00) && (PADDR_I <= REG_UIDDAT);
	wire        engine    = (state_q != ST_IDLE);
	wire        cmd_wr    = apb_wr && known && (PADDR_I == REG_CMD);
	wire [3:0]  cmd_new   = PWDATA_I[3:0];
	wire        cmd_ok    = cmd_wr && !engine && DEV_BUSY_N_I && (cmd_new != CMD_NONE);
	wire        cmd_bad   = cmd_wr && (engine || !DEV_BUSY_N_I);
	wire        rej_clr   = apb_wr && known && (PADDR_I == REG_STATUS) && PWDATA_I[ST_REJ_BIT];
	wire        cnt_done  = (cnt_q == 10'h000);
	wire        cur_wr    = cur[30];
	wire        cur_last  = cur[29];
	wire        strobe_on = (state_q == ST_STROBE);
	wire        uid_we    = strobe_on && cnt_done && (cmd_q == CMD_UID);

	assign cur = step_fn(cmd_q, step_q, addr_q, wdata_q);

	////////////////////////////////////////////////////////////////////////////
	// sequencer: one device cycle is setup, strobe window, recovery
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_done ? 10'h000 : cnt_q - 10'h001;
		case (state_q)
			ST_RST_PULSE:
				if (cnt_done)
					state_d = ST_BUSY_WAIT;
			ST_BUSY_WAIT:
				if (DEV_BUSY_N_I)
					state_d = ST_IDLE;
			ST_IDLE:
				if (cmd_ok && cmd_new == CMD_HWRST)
				begin
					state_d = ST_RST_PULSE;
					cnt_d   = 10'(RESET_INPUT_N_CYC - 1);
				end
				else if (cmd_ok)
					state_d = ST_SETUP;
			ST_SETUP:
			begin
				state_d = ST_STROBE;
				cnt_d   = 10'(STROBE_CYC - 1);
			end
			ST_STROBE:
				if (cnt_done)
					state_d = ST_RECOVER;
			ST_RECOVER:
				if (!cur_last)
					state_d = ST_SETUP;
				else if (cmd_q == CMD_WAKE)
				begin
					state_d = ST_WAKE_WAIT;
					cnt_d   = 10'(WAKE_CYC - 1);
				end
				else
					state_d = ST_IDLE;
			ST_WAKE_WAIT:
				if (cnt_done)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// reset pulse comes first so the download runs before any access
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			state_q <= ST_RST_PULSE;
			cnt_q   <= 10'(RESET_INPUT_N_CYC - 1);
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// step counter advances after each recovered device cycle
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			step_q <= 5'h00;
		else if (state_q == ST_IDLE)
			step_q <= 5'h00;
		else if (state_q == ST_RECOVER)
			step_q <= step_q + 5'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			cmd_q     <= CMD_NONE;
			addr_q    <= 13'h0000;
			wdata_q   <= 16'h0000;
			lock_q    <= 1'b0;
			uid_idx_q <= 4'h0;
		end
		else
		begin
			if (cmd_ok)
				cmd_q <= cmd_new;
			if (apb_wr && PADDR_I == REG_ADDR)
				addr_q <= PWDATA_I[12:0];
			if (apb_wr && PADDR_I == REG_WDATA)
				wdata_q <= PWDATA_I[15:0];
			if (apb_wr && PADDR_I == REG_CFG)
				lock_q <= PWDATA_I[CFG_LOCK_BIT];
			if (apb_wr && PADDR_I == REG_UIDIDX)
				uid_idx_q <= PWDATA_I[3:0];
		end
	end

	// refused command flag; a new refusal beats the clear
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			rej_q <= 1'b0;
		else
			rej_q <= cmd_bad | (rej_q & ~rej_clr);
	end

	// capture read data on the last strobe cycle, while output enable is still low
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			rdata_q <= 16'h0000;
		else if (strobe_on && cnt_done && !cur_wr)
			rdata_q <= DEV_D_I;
	end

	pbmc_mem u_mem (
		.clk_i   (CLK_I),
		.we_i    (uid_we),
		.waddr_i (step_q[3:0]),
		.wdata_i (DEV_D_I[7:0]),
		.raddr_i (uid_idx_q),
		.rdata_o (uid_byte)
	);

	////////////////////////////////////////////////////////////////////////////
	// apb read mux; zero wait states, error on unmapped offsets
	wire [31:0] status_w = {27'h0000000, lock_q, rej_q, ~DEV_IRQ_N_I, ~DEV_BUSY_N_I, engine};
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = apb_acc & ~known;
	always_comb
	begin
		PRDATA_O = 32'h00000000;
		if (apb_acc && !PWRITE_I && known)
			case (PADDR_I)
				REG_CMD:    PRDATA_O = {28'h0000000, cmd_q};
				REG_ADDR:   PRDATA_O = {19'h00000, addr_q};
				REG_WDATA:  PRDATA_O = {16'h0000, wdata_q};
				REG_RDATA:  PRDATA_O = {16'h0000, rdata_q};
				REG_STATUS: PRDATA_O = status_w;
				REG_CFG:    PRDATA_O = {31'h00000000, lock_q};
				REG_UIDIDX: PRDATA_O = {28'h0000000, uid_idx_q};
				REG_UIDDAT: PRDATA_O = {24'h000000, uid_byte};
				default:    PRDATA_O = 32'h00000000;
			endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// device pins: address and data settle in setup, strobes only in the window
	logic [12:0] dev_addr_q;
	logic [15:0] dev_d_q;
	logic        dev_oe_q;
	logic        ce_n_q;
	logic        oe_n_q;
	logic        we_n_q;
	logic        reset_input_n_n_q;
	wire         strobe_next = (state_d == ST_STROBE) || (state_q == ST_STROBE && !cnt_done);
	// the first step must come from the command being accepted, not from the previous one
	wire  [3:0]  cmd_sel     = (state_q == ST_IDLE) ? cmd_new : cmd_q;
	wire  [4:0]  step_sel    = (state_q == ST_IDLE) ? 5'h00 : step_q + 5'h01;
	wire  [30:0] nxt         = step_fn(cmd_sel, step_sel, addr_q, wdata_q);

	// strobes come from flops so the device sees glitch-free edges
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			dev_addr_q <= 13'h0000;
			dev_d_q    <= 16'h0000;
			dev_oe_q   <= 1'b0;
			ce_n_q     <= 1'b1;
			oe_n_q     <= 1'b1;
			we_n_q     <= 1'b1;
			reset_input_n_n_q  <= 1'b0;
		end
		else
		begin
			if (state_d == ST_SETUP)
			begin
				dev_addr_q <= nxt[28:16];
				dev_d_q    <= nxt[15:0];
			end
			dev_oe_q  <= (state_d == ST_SETUP) ? nxt[30] : ((state_d == ST_STROBE) && cur_wr);
			ce_n_q    <= ~strobe_next;
			oe_n_q    <= ~(strobe_next && !cur_wr);
			we_n_q    <= ~(strobe_next && cur_wr);
			reset_input_n_n_q <= (state_d != ST_RST_PULSE);
		end
	end

	assign DEV_ADDR_O    = dev_addr_q;
	assign DEV_D_O       = dev_d_q;
	assign DEV_D_OE_O    = dev_oe_q;
	assign DEV_CE_N_O    = ce_n_q;
	assign DEV_OE_N_O    = oe_n_q;
	assign DEV_WE_N_O    = we_n_q;
	assign DEV_RESET_INPUT_N_N_O = reset_input_n_n_q;
	assign DEV_LOCK_N_O  = ~lock_q;
endmodule
`default_nettype wire

// file: pbmc_pkg.sv
`default_nettype none
package pbmc_pkg;
	// apb map of the controller's own registers
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_CFG    = 8'h14;
	localparam logic [7:0] REG_UIDIDX = 8'h18;
	localparam logic [7:0] REG_UIDDAT = 8'h1C;

	// status bit positions
	localparam int ST_ENGINE_BIT = 0;
	localparam int ST_DEVBSY_BIT = 1;
	localparam int ST_IRQ_BIT    = 2;
	localparam int ST_REJ_BIT    = 3;
	localparam int ST_LOCK_BIT   = 4;
	localparam int CFG_LOCK_BIT  = 0;

	// commands written to the command register
	localparam logic [3:0] CMD_NONE   = 4'h0;
	localparam logic [3:0] CMD_READ   = 4'h1;
	localparam logic [3:0] CMD_WRITE  = 4'h2;
	localparam logic [3:0] CMD_NORMAL = 4'h3;
	localparam logic [3:0] CMD_RSTMOD = 4'h4;
	localparam logic [3:0] CMD_SLEEP  = 4'h5;
	localparam logic [3:0] CMD_WAKE   = 4'h6;
	localparam logic [3:0] CMD_UID    = 4'h7;
	localparam logic [3:0] CMD_STICKY_LOCK_BIT  = 4'h8;
	localparam logic [3:0] CMD_HWRST  = 4'h9;

	// device window addresses and mode codes
	localparam logic [12:0] DEV_CTRL_ADDR   = 13'h1000;
	localparam logic [12:0] DEV_CONF_ADDR   = 13'h1002;
	localparam logic [12:0] DEV_NOP_ADDR    = 13'h1004;
	localparam logic [12:0] DEV_OUTCTL_ADDR = 13'h1006;
	localparam logic [12:0] DEV_UID_BASE    = 13'h1100;
	localparam logic [15:0] MODE_RESET      = 16'h0004;
	localparam logic [15:0] MODE_NORMAL     = 16'h0005;
	localparam logic [15:0] MODE_DEEP       = 16'h0006;
	localparam logic [15:0] STICKY_LOCK_BIT_MASK      = 16'h0008;
	localparam int          UID_BYTES       = 16;

	// timing
	localparam int CLK_MHZ     = 200;
	localparam int STROBE_NS   = 80;
	localparam int RESET_INPUT_N_NS    = 1000;
	localparam int WAKE_NS     = 3000;
	localparam int STROBE_CYC  = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_INPUT_N_CYC   = (RESET_INPUT_N_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_CYC    = (WAKE_NS * CLK_MHZ + 999) / 1000;

	typedef enum {
		ST_RST_PULSE,
		ST_BUSY_WAIT,
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_RECOVER,
		ST_WAKE_WAIT
	} pbmc_state_e;
endpackage
`default_nettype wire

// file: pbmc_mem.sv
`timescale 1ns/100ps
`default_nettype none
module pbmc_mem
	import pbmc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       we_i,
	input  wire logic [3:0] waddr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [3:0] raddr_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem_q [0:UID_BYTES-1];

	// no reset on the array; readers only see bytes after a serial fetch
	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem_q[waddr_i] <= wdata_i;
		rdata_o <= mem_q[raddr_i];
	end
endmodule
`default_nettype wire

// file: pbmc_host_end.sv
`default_nettype none
`default_nettype wire

// file: pbmc_host_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pbmc_host_checker
	import pbmc_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic [12:0] DEV_ADDR_O,
	input  wire logic [15:0] DEV_D_O,
	input  wire logic        DEV_D_OE_O,
	input  wire logic        DEV_CE_N_O,
	input  wire logic        DEV_OE_N_O,
	input  wire logic        DEV_WE_N_O,
	input  wire logic        DEV_RESET_INPUT_N_N_O,
	input  wire logic        DEV_BUSY_N_I
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic [9:0] wake_q;
	////////////////////////////////////////////////////////////////////////////////
	// a wakeup read opens a quiet window; a repetition cannot span 600 cycles
	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			wake_q <= 10'h000;
		else if ($rose(DEV_CE_N_O) && DEV_ADDR_O == DEV_NOP_ADDR && !$past(DEV_OE_N_O))
			wake_q <= 10'(WAKE_CYC - 1);
		else if (wake_q != 10'h000)
			wake_q <= wake_q - 10'h001;
	end
	sequence s_held;
		(!DEV_CE_N_O && $stable(DEV_ADDR_O) && $stable(DEV_D_O)) [*8];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_busy_no_access: assert property (!DEV_BUSY_N_I |-> DEV_CE_N_O) else $error("access while busy");
	a_reset_input_n_no_access: assert property (!DEV_RESET_INPUT_N_N_O |-> DEV_CE_N_O) else $error("access in reset");
	a_strobe_excl: assert property (!(!DEV_OE_N_O && !DEV_WE_N_O)) else $error("read and write strobes");
	a_strobe_ce: assert property (!(DEV_OE_N_O && DEV_WE_N_O) |-> !DEV_CE_N_O) else $error("strobe w/o ce");
	a_strobe_len: assert property ($fell(DEV_CE_N_O) |-> s_held ##1 s_held ##1 DEV_CE_N_O)
		else $error("strobe not 16 clean cycles");
	a_cycle_gap: assert property ($rose(DEV_CE_N_O) |-> DEV_CE_N_O ##1 DEV_CE_N_O) else $error("gap short");
	a_data_drive: assert property (!DEV_CE_N_O |-> DEV_D_OE_O == !DEV_WE_N_O) else $error("data drive");
	a_wake_quiet: assert property (wake_q != 10'h000 |-> DEV_CE_N_O) else $error("access in wake wait");
endmodule
`default_nettype wire

// file: pbmc_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbmc_dev_model
	import pbmc_pkg::*;
#(
	parameter int          BUSY_NS   = 500,
	parameter logic [12:0] PROT_ADDR = 13'h0200,
	parameter logic [15:0] PROT_DATA = 16'h5AC3
)
(
	input  wire logic [12:0] addr_i,
	input  wire logic [15:0] data_i,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        reset_input_n_n_i,
	input  wire logic        lock_n_i,
	output logic      [15:0] data_o,
	output logic             busy_n_o,
	output logic             irq_n_o
);
	logic [15:0] mode;
	logic [15:0] pend;
	logic        sticky_lock_bit;
	// idle standby is invisible at the pins, so it needs no state here
	initial
	begin
		data_o = 16'hFFFF;
		busy_n_o = 1'b0;
		irq_n_o = 1'b1;
		mode = MODE_RESET;
		pend = 16'h0000;
		sticky_lock_bit = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// reset pin: reset mode, lock cleared, busy while the download runs
	always @(negedge reset_input_n_n_i)
	begin
		busy_n_o = 1'b0;
		irq_n_o = 1'b1;
		mode = MODE_RESET;
		sticky_lock_bit = 1'b0;
	end
	always @(posedge reset_input_n_n_i)
	begin
		#(BUSY_NS); // loader copy and rule load happen here
		busy_n_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// write cycle: settle a step after the strobe so address and data are seen
	always @(negedge we_n_i)
	begin
		#1;
		if (!ce_n_i && busy_n_o)
		begin
			if (addr_i == DEV_CTRL_ADDR)
				pend = data_i;
			else if (addr_i == DEV_CONF_ADDR && data_i == ~pend && (pend != MODE_DEEP || mode == MODE_NORMAL))
				mode = pend;
			else if (addr_i == DEV_OUTCTL_ADDR && mode == MODE_NORMAL && (data_i & STICKY_LOCK_BIT_MASK) != 16'h0000)
				sticky_lock_bit = 1'b1; // set only, no write clears it
		end
	end
	// read cycle; deep sleep drives the previous word inverted instead of read data
	always @(negedge oe_n_i)
	begin
		#1;
		if (!ce_n_i && mode == MODE_DEEP)
		begin
			data_o = ~data_o;
			if (addr_i == DEV_NOP_ADDR)
				#3000 mode = MODE_NORMAL;
		end
		else if (!ce_n_i)
		begin
			if (mode != MODE_RESET && addr_i == PROT_ADDR && (sticky_lock_bit || !lock_n_i))
				irq_n_o = 1'b0; // violation raises the request until the next reset
			data_o = mode == MODE_RESET ? 16'h0000
				: addr_i == DEV_CTRL_ADDR ? mode
				: addr_i[12:4] == DEV_UID_BASE[12:4] ? {8'hA0 + 8'(addr_i[3:0]), 8'hA0 + 8'(addr_i[3:0])}
				: addr_i == PROT_ADDR && (sticky_lock_bit || !lock_n_i) ? 16'h0000
				: PROT_DATA;
		end
	end
	// a released bus must not keep showing the last word
	always @(posedge oe_n_i)
		data_o = ~data_o;
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
	import pbmc_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, d_oe, slv;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [12:0] daddr;
	logic [15:0] din, dout;
	logic ce_n, oe_n, we_n, reset_input_n_n, lock_n, busy_n, irq_n;
	int error_cnt = 0, checks = 0;
	always #2.5 clk = ~clk;
	pbmc_host u_pbmc_host (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.DEV_ADDR_O(daddr), .DEV_D_I(din), .DEV_D_O(dout), .DEV_D_OE_O(d_oe), .DEV_CE_N_O(ce_n),
		.DEV_OE_N_O(oe_n), .DEV_WE_N_O(we_n), .DEV_RESET_INPUT_N_N_O(reset_input_n_n), .DEV_LOCK_N_O(lock_n),
		.DEV_BUSY_N_I(busy_n), .DEV_IRQ_N_I(irq_n));
	pbmc_dev_model u_pbmc_dev_model (.addr_i(daddr), .data_i(dout), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
		.reset_input_n_n_i(reset_input_n_n), .lock_n_i(lock_n), .data_o(din), .busy_n_o(busy_n), .irq_n_o(irq_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; read data is the value captured at the taking edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			error_cnt++;
		if (n >= 50)
			end_sim();
	endtask
	// polling keeps the wait bounded however slow the device is
	task automatic cmd(input logic [3:0] c);
		int n;
		apb(1'b1, REG_CMD, {28'h0, c});
		n = 0;
		do
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while ((r[ST_ENGINE_BIT] !== 1'b0 || r[ST_DEVBSY_BIT] !== 1'b0) && n < 2000);
		if (n >= 2000)
			error_cnt++;
		if (n >= 2000)
			end_sim();
	endtask
	task automatic dev_rd(input logic [12:0] a, input logic [15:0] e);
		apb(1'b1, REG_ADDR, {19'h0, a});
		cmd(CMD_READ);
		apb(1'b0, REG_RDATA, 32'h0);
		chk(r[15:0], e);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b1, REG_CMD, {28'h0, CMD_NORMAL});
		apb(1'b0, REG_STATUS, 32'h0);
		chk(16'(r[ST_REJ_BIT]), 16'h0001);
		apb(1'b1, REG_STATUS, 32'h00000008);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(16'(r[ST_REJ_BIT]), 16'h0000);
		cmd(CMD_NONE);
		dev_rd(DEV_CTRL_ADDR, 16'h0000);
		cmd(CMD_NORMAL);
		dev_rd(DEV_CTRL_ADDR, MODE_NORMAL);
		$display("test boot and modes done");
		cmd(CMD_UID);
		for (int i = 0; i < UID_BYTES; i++)
		begin
			apb(1'b1, REG_UIDIDX, 32'(i));
			apb(1'b0, REG_UIDDAT, 32'h0);
			chk(r[15:0], 16'h00A0 + 16'(i));
		end
		$display("test serial done");
		dev_rd(13'h0200, 16'h5AC3);
		apb(1'b1, REG_CFG, 32'h1);
		dev_rd(13'h0200, 16'h0000);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(16'(r[ST_IRQ_BIT]), 16'h0001);
		apb(1'b1, REG_CFG, 32'h0);
		cmd(CMD_STICKY_LOCK_BIT);
		dev_rd(13'h0200, 16'h0000);
		apb(1'b1, REG_ADDR, {19'h0, DEV_OUTCTL_ADDR});
		apb(1'b1, REG_WDATA, 32'h0);
		cmd(CMD_WRITE);
		dev_rd(13'h0200, 16'h0000);
		$display("test lock done");
		cmd(CMD_SLEEP);
		cmd(CMD_WAKE);
		dev_rd(DEV_CTRL_ADDR, MODE_NORMAL);
		cmd(CMD_HWRST);
		dev_rd(DEV_CTRL_ADDR, 16'h0000);
		cmd(CMD_NORMAL);
		dev_rd(13'h0200, 16'h5AC3);
		cmd(CMD_RSTMOD);
		dev_rd(DEV_CTRL_ADDR, 16'h0000);
		apb(1'b0, 8'h20, 32'h0);
		chk(r[15:0], 16'h0000);
		chk(16'(slv), 16'h0001);
		$display("test reset and sleep done");
		end_sim();
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		end_sim();
	end
endmodule
bind pbmc_host pbmc_host_checker u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .DEV_ADDR_O(DEV_ADDR_O),
	.DEV_D_O(DEV_D_O), .DEV_D_OE_O(DEV_D_OE_O), .DEV_CE_N_O(DEV_CE_N_O), .DEV_OE_N_O(DEV_OE_N_O),
	.DEV_WE_N_O(DEV_WE_N_O), .DEV_RESET_INPUT_N_N_O(DEV_RESET_INPUT_N_N_O), .DEV_BUSY_N_I(DEV_BUSY_N_I));
`default_nettype wire
